// ### include/pmr_pkg.sv
package pmr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SYNTH_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_SYNTH_CFG   = 8'h04;
  localparam logic [7:0] ADDR_CLK_SEL     = 8'h08;
  localparam logic [7:0] ADDR_CPU_DIV     = 8'h0C;
  localparam logic [7:0] ADDR_USB_DIV     = 8'h10;
  localparam logic [7:0] ADDR_PWR_MODE    = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;
  localparam logic [7:0] ADDR_PCLK_GATE   = 8'h1C;
  localparam logic [7:0] ADDR_PCLK_DIV    = 8'h20;

  // Field positions
  localparam int SYNTH_EN_BIT      = 0;
  localparam int SYNTH_CONNECT_BIT = 1;
  localparam int CFG_N_LSB         = 0;
  localparam int CFG_M_LSB         = 8;

  // Reset values
  localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;
  localparam logic [31:0] PCLK_GATE_RESET = 32'h0000_FFFF;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ           = 20_000_000;
  localparam int RC_START_US        = 60;
  localparam int RC_START_CYCLES    = (RC_START_US * (CLOCK_HZ / 1_000_000));
  localparam int SLEEP_RC_CYCLES    = 4;
  localparam int SLEEP_MAIN_CYCLES  = 4096;
  localparam int RESET_HOLD_CYCLES  = 4096;
  localparam int NUM_PERIPH         = 16;
  localparam int NUM_SOURCES        = 3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_RC   = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_RTC  = 2'h2
  } clk_src_t;

  typedef enum logic [2:0] {
    MODE_RUN   = 3'h0,
    MODE_IDLE  = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_PDOWN = 3'h3,
    MODE_DEEP  = 3'h4
  } pwr_mode_t;

  // Gray in declared order: reset, run, idle, low power, RC start, wake, deep
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_RUN     = 3'b001,
    ST_IDLE    = 3'b011,
    ST_LOWPWR  = 3'b010,
    ST_RCSTART = 3'b110,
    ST_WAKE    = 3'b111,
    ST_DEEP    = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic pin;
    logic watchdog;
    logic power_on;
    logic brownout_detector;
  } reset_src_t;

  typedef struct packed {
    logic external_int;
    logic clockless_int;
    logic rtc_alarm;
  } wake_src_t;

  typedef struct packed {
    logic [8:0]  n;
    logic [15:0] m;
  } synth_cfg_t;

endpackage

// ### hw/power_mode_reset_sequencer.sv
module power_mode_reset_sequencer (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]                       address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [31:0]                      writedata,
  input  wire logic [3:0]                       byteenable,
  output logic      [31:0]                      readdata,
  output logic                                  waitrequest,
  // Reset and wake sources
  input  wire pmr_pkg::reset_src_t              reset_src,
  input  wire pmr_pkg::wake_src_t               wake_src,
  input  wire logic                             irq_pending,
  // Oscillator status
  input  wire logic                             main_osc_running,
  input  wire logic                             synth_phase_lock,
  // Sequencer outputs
  output logic                                  chip_reset_n,
  output logic                                  cpu_run,
  output logic                                  internal_rc_oscillator_power,
  output logic                                  internal_rc_oscillator_gate,
  output logic                                  regulator_on,
  output logic                                  boot_start,
  output pmr_pkg::clk_src_t                     synth_reference_sel,
  output logic                                  synth_enable,
  output logic                                  synth_connected,
  output pmr_pkg::synth_cfg_t                   synth_cfg,
  output pmr_pkg::clk_src_t                     processor_clock_src,
  output logic [7:0]                            processor_clock_div,
  output logic [7:0]                            usb_clock_div,
  output logic [pmr_pkg::NUM_PERIPH-1:0]        periph_clk_gate,
  output logic [2*pmr_pkg::NUM_PERIPH-1:0]      periph_clk_div
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pmr_pkg::seq_state_t state;
  pmr_pkg::clk_src_t   prior_src;
  pmr_pkg::pwr_mode_t  mode_req;
  logic [12:0]         timer;
  logic                any_reset;
  logic                wr_hit;
  logic                mode_go;
  logic                bus_done;
  logic                pend_src;
  pmr_pkg::clk_src_t   src_target;
  logic [1:0]          switch_cnt;

  // Address match against one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Clamp divide or multiply value into its legal range
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] hi);
    if (v == 16'h0000) begin
      clamp = 16'h0001;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // ---------------------------------------------------------------
  // Reset merge
  // ---------------------------------------------------------------
  assign any_reset = reset_src.pin | reset_src.watchdog | reset_src.power_on
                   | reset_src.brownout_detector;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // One wait cycle, then answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_done <= 1'b0;
    end else if ((read || write) && !bus_done) begin
      bus_done <= 1'b1;
    end else begin
      bus_done <= 1'b0;
    end
  end

  assign wr_hit  = write && bus_done;
  assign mode_go = wr_hit && hit(address, pmr_pkg::ADDR_PWR_MODE) && byteenable[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && !bus_done);
    end
  end

  // Read data mux
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= pmr_pkg::RESET_ZERO;
    end else if (read && !bus_done) begin
      if (hit(address, pmr_pkg::ADDR_SYNTH_CTRL)) begin
        readdata <= {30'h0000_0000, synth_connected, synth_enable};
      end else if (hit(address, pmr_pkg::ADDR_SYNTH_CFG)) begin
        readdata <= {synth_cfg.m, 7'h00, synth_cfg.n};
      end else if (hit(address, pmr_pkg::ADDR_CLK_SEL)) begin
        readdata <= {26'h000_0000, synth_reference_sel, 2'h0, processor_clock_src};
      end else if (hit(address, pmr_pkg::ADDR_CPU_DIV)) begin
        readdata <= {24'h00_0000, processor_clock_div};
      end else if (hit(address, pmr_pkg::ADDR_USB_DIV)) begin
        readdata <= {24'h00_0000, usb_clock_div};
      end else if (hit(address, pmr_pkg::ADDR_PWR_MODE)) begin
        readdata <= {29'h0000_0000, mode_req};
      end else if (hit(address, pmr_pkg::ADDR_STATUS)) begin
        readdata <= {24'h00_0000, switch_cnt != 2'h0, main_osc_running,
                     synth_phase_lock, 2'h0, state};
      end else if (hit(address, pmr_pkg::ADDR_PCLK_GATE)) begin
        readdata <= {16'h0000, periph_clk_gate};
      end else if (hit(address, pmr_pkg::ADDR_PCLK_DIV)) begin
        readdata <= periph_clk_div;
      end else begin
        readdata <= pmr_pkg::UNMAPPED_READ;
      end
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer control
  // ---------------------------------------------------------------
  // Enable and connect; cleared by reset, Sleep and Power-down entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      synth_enable    <= 1'b0;
      synth_connected <= 1'b0;
    end else if (any_reset || state == pmr_pkg::ST_RESET || state == pmr_pkg::ST_LOWPWR) begin
      synth_enable    <= 1'b0;
      synth_connected <= 1'b0;
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_SYNTH_CTRL) && byteenable[0]) begin
      synth_enable    <= writedata[pmr_pkg::SYNTH_EN_BIT];
      // Connect only when enabled and locked
      synth_connected <= writedata[pmr_pkg::SYNTH_CONNECT_BIT] && synth_enable
                         && synth_phase_lock;
    end else if (!synth_enable || !synth_phase_lock) begin
      synth_connected <= 1'b0;
    end
  end

  // N stored 1..256, M stored 1..32768; feedback divides by M
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      synth_cfg <= {9'h001, 16'h0001};
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_SYNTH_CFG) && (&byteenable)) begin
      synth_cfg.n <= 9'(clamp({7'h00, writedata[8:0]}, 16'h0100));
      synth_cfg.m <= clamp(writedata[31:16], 16'h8000);
    end
  end

  // ---------------------------------------------------------------
  // Clock sources and dividers
  // ---------------------------------------------------------------
  // Source request; back to RC after reset or deep wake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_target          <= pmr_pkg::SRC_RC;
      synth_reference_sel <= pmr_pkg::SRC_RC;
    end else if (any_reset || state == pmr_pkg::ST_RESET) begin
      src_target          <= pmr_pkg::SRC_RC;
      synth_reference_sel <= pmr_pkg::SRC_RC;
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_CLK_SEL) && byteenable[0]) begin
      src_target          <= pmr_pkg::clk_src_t'(writedata[1:0]);
      synth_reference_sel <= pmr_pkg::clk_src_t'(writedata[5:4]);
    end
  end

  // Break-before-make switch: gate off, wait, change, reopen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      processor_clock_src <= pmr_pkg::SRC_RC;
      switch_cnt          <= 2'h0;
    end else if (switch_cnt != 2'h0) begin
      switch_cnt <= switch_cnt - 2'h1;
      if (switch_cnt == 2'h2) begin
        processor_clock_src <= src_target;
      end
    end else if (src_target != processor_clock_src) begin
      switch_cnt <= 2'h3;
    end
  end

  assign pend_src = (switch_cnt != 2'h0);

  // Processor and USB dividers, cleared on Sleep entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      processor_clock_div <= 8'h00;
      usb_clock_div       <= 8'h00;
    end else if (state == pmr_pkg::ST_LOWPWR || state == pmr_pkg::ST_RESET) begin
      processor_clock_div <= 8'h00;
      usb_clock_div       <= 8'h00;
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_CPU_DIV) && byteenable[0]) begin
      processor_clock_div <= writedata[7:0];
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_USB_DIV) && byteenable[0]) begin
      usb_clock_div <= writedata[7:0];
    end
  end

  // Per-peripheral gates and two-bit dividers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periph_clk_gate <= pmr_pkg::PCLK_GATE_RESET[15:0];
      periph_clk_div  <= pmr_pkg::RESET_ZERO;
    end else if (state == pmr_pkg::ST_RESET) begin
      periph_clk_gate <= pmr_pkg::PCLK_GATE_RESET[15:0];
      periph_clk_div  <= pmr_pkg::RESET_ZERO;
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_PCLK_GATE) && (&byteenable[1:0])) begin
      periph_clk_gate <= writedata[15:0];
    end else if (wr_hit && hit(address, pmr_pkg::ADDR_PCLK_DIV) && (&byteenable)) begin
      periph_clk_div <= writedata;
    end
  end

  // ---------------------------------------------------------------
  // Power sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= pmr_pkg::ST_RESET;
      timer     <= 13'h0000;
      mode_req  <= pmr_pkg::MODE_RUN;
      prior_src <= pmr_pkg::SRC_RC;
    end else if (any_reset) begin
      state <= pmr_pkg::ST_RESET;
      timer <= 13'h0000;
      mode_req <= pmr_pkg::MODE_RUN;
    end else begin
      case (state)
        pmr_pkg::ST_RESET: begin
          // Hold until oscillator runs and fixed count elapses
          if (!main_osc_running) begin
            timer <= 13'h0000;
          end else if (timer == 13'(pmr_pkg::RESET_HOLD_CYCLES - 1)) begin
            state <= pmr_pkg::ST_RUN;
            timer <= 13'h0000;
          end else begin
            timer <= timer + 13'h0001;
          end
        end
        pmr_pkg::ST_RUN: begin
          if (mode_go && !pend_src) begin
            mode_req  <= pmr_pkg::pwr_mode_t'(writedata[2:0]);
            prior_src <= processor_clock_src;
            if (writedata[2:0] == pmr_pkg::MODE_IDLE) begin
              state <= pmr_pkg::ST_IDLE;
            end else if (writedata[2:0] == pmr_pkg::MODE_DEEP) begin
              state <= pmr_pkg::ST_DEEP;
            end else if (writedata[2:0] == pmr_pkg::MODE_SLEEP
                         || writedata[2:0] == pmr_pkg::MODE_PDOWN) begin
              state <= pmr_pkg::ST_LOWPWR;
            end
          end
        end
        pmr_pkg::ST_IDLE: begin
          if (irq_pending) begin
            state    <= pmr_pkg::ST_RUN;
            mode_req <= pmr_pkg::MODE_RUN;
          end
        end
        pmr_pkg::ST_LOWPWR: begin
          // Only clockless interrupts, RTC or external wake
          if (wake_src.clockless_int || wake_src.rtc_alarm || wake_src.external_int) begin
            timer <= 13'h0000;
            if (mode_req == pmr_pkg::MODE_PDOWN && prior_src == pmr_pkg::SRC_RC) begin
              state <= pmr_pkg::ST_RCSTART;
            end else begin
              state <= pmr_pkg::ST_WAKE;
            end
          end
        end
        pmr_pkg::ST_RCSTART: begin
          if (timer == 13'(pmr_pkg::RC_START_CYCLES - 1)) begin
            state <= pmr_pkg::ST_WAKE;
            timer <= 13'h0000;
          end else begin
            timer <= timer + 13'h0001;
          end
        end
        pmr_pkg::ST_WAKE: begin
          // RC: 4 cycles; main oscillator: 4096 once it runs
          if (prior_src == pmr_pkg::SRC_RC && timer == 13'(pmr_pkg::SLEEP_RC_CYCLES - 1)) begin
            state    <= pmr_pkg::ST_RUN;
            mode_req <= pmr_pkg::MODE_RUN;
          end else if (prior_src != pmr_pkg::SRC_RC && !main_osc_running) begin
            timer <= 13'h0000;
          end else if (prior_src != pmr_pkg::SRC_RC
                       && timer == 13'(pmr_pkg::SLEEP_MAIN_CYCLES - 1)) begin
            state    <= pmr_pkg::ST_RUN;
            mode_req <= pmr_pkg::MODE_RUN;
          end else begin
            timer <= timer + 13'h0001;
          end
        end
        pmr_pkg::ST_DEEP: begin
          // Wake restarts through full reset sequence
          if (wake_src.rtc_alarm) begin
            state <= pmr_pkg::ST_RESET;
            timer <= 13'h0000;
            mode_req <= pmr_pkg::MODE_RUN;
          end
        end
        default: begin
          state <= pmr_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_n                 <= 1'b0;
      cpu_run                      <= 1'b0;
      internal_rc_oscillator_power <= 1'b1;
      internal_rc_oscillator_gate  <= 1'b1;
      regulator_on                 <= 1'b1;
      boot_start                   <= 1'b0;
    end else begin
      chip_reset_n <= !any_reset && state != pmr_pkg::ST_RESET;
      cpu_run      <= state == pmr_pkg::ST_RUN && !any_reset && !pend_src;
      internal_rc_oscillator_gate  <= !(state == pmr_pkg::ST_LOWPWR
                                      || state == pmr_pkg::ST_DEEP);
      internal_rc_oscillator_power <= !((state == pmr_pkg::ST_LOWPWR
                                       && mode_req == pmr_pkg::MODE_PDOWN)
                                      || state == pmr_pkg::ST_DEEP);
      regulator_on <= state != pmr_pkg::ST_DEEP;
      // Pulse in the cycle that internal reset lets go
      boot_start   <= !any_reset && state != pmr_pkg::ST_RESET && !chip_reset_n;
    end
  end

endmodule

// ### verif/power_mode_reset_sequencer_monitor.sv
module power_mode_reset_sequencer_monitor (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst_n,
  // Sources
  input wire pmr_pkg::reset_src_t reset_src,
  input wire pmr_pkg::wake_src_t  wake_src,
  input wire logic                synth_phase_lock,
  // Sequencer outputs
  input wire logic                chip_reset_n,
  input wire logic                cpu_run,
  input wire logic                internal_rc_oscillator_power,
  input wire logic                internal_rc_oscillator_gate,
  input wire logic                regulator_on,
  input wire logic                boot_start,
  input wire logic                synth_enable,
  input wire logic                synth_connected,
  input wire pmr_pkg::clk_src_t   processor_clock_src,
  input wire logic [7:0]          processor_clock_div,
  input wire logic [7:0]          usb_clock_div
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] hold_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Cycles spent in internal reset since the last source
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) hold_cnt <= '0;
    else if (chip_reset_n || |reset_src) hold_cnt <= '0;
    else if (hold_cnt != 13'h1FFF) hold_cnt <= hold_cnt + 13'h1;
  end
  property p_src_reset; |reset_src |-> ##[0:2] !chip_reset_n; endproperty
  a_src_reset: assert property (p_src_reset) else $error("reset source ignored");
  property p_hold; $rose(chip_reset_n) |-> hold_cnt >= 13'h1000; endproperty
  a_hold: assert property (p_hold) else $error("internal reset released early");
  property p_boot; $rose(chip_reset_n) |-> ##[0:1] (boot_start ##1 !boot_start); endproperty
  a_boot: assert property (p_boot) else $error("boot pulse missing");
  property p_rc_release;
    $rose(chip_reset_n) |-> processor_clock_src == pmr_pkg::SRC_RC && !synth_enable && !synth_connected;
  endproperty
  a_rc_release: assert property (p_rc_release) else $error("bad clock state at release");
  property p_connect; $rose(synth_connected) |-> synth_enable && $past(synth_phase_lock); endproperty
  a_connect: assert property (p_connect) else $error("connected without lock");
  property p_sleep_entry;
    $fell(internal_rc_oscillator_gate) |-> ##[0:1]
      (!synth_enable && !synth_connected && processor_clock_div == 8'h00 && usb_clock_div == 8'h00);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry left clocks set");
  property p_gate_stop; !internal_rc_oscillator_gate |-> !cpu_run; endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("running with clock gated");
  property p_pd; !internal_rc_oscillator_power |-> !internal_rc_oscillator_gate && !cpu_run; endproperty
  a_pd: assert property (p_pd) else $error("oscillator off but output live");
  property p_deep_stay;
    !regulator_on && !wake_src.rtc_alarm && !(|reset_src) |=> !regulator_on;
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("deep mode left without cause");
  c_sleep: cover property ($fell(internal_rc_oscillator_gate));
  c_pd: cover property ($fell(internal_rc_oscillator_power));
  c_deep: cover property ($fell(regulator_on));
  c_boot: cover property ($rose(chip_reset_n));
endmodule

bind power_mode_reset_sequencer power_mode_reset_sequencer_monitor i_mon (.clock(clock), .rst_n(rst_n),
  .reset_src(reset_src), .wake_src(wake_src), .synth_phase_lock(synth_phase_lock),
  .chip_reset_n(chip_reset_n), .cpu_run(cpu_run), .internal_rc_oscillator_power(internal_rc_oscillator_power),
  .internal_rc_oscillator_gate(internal_rc_oscillator_gate), .regulator_on(regulator_on),
  .boot_start(boot_start), .synth_enable(synth_enable), .synth_connected(synth_connected),
  .processor_clock_src(processor_clock_src), .processor_clock_div(processor_clock_div),
  .usb_clock_div(usb_clock_div));

// ### verif/osc_partner.sv
module osc_partner (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Synthesizer control
  input  wire logic synth_enable,
  // Oscillator status
  output logic      main_osc_running,
  output logic      synth_phase_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] osc_cnt;
  logic [4:0] lock_cnt;
  // Crystal needs a while after power-on to swing fully
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) osc_cnt <= '0;
    else if (osc_cnt != 4'hF) osc_cnt <= osc_cnt + 4'h1;
  end
  assign main_osc_running = (osc_cnt == 4'hF);
  // Loop settles some cycles after enable, lost when disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n || !synth_enable) lock_cnt <= '0;
    else if (lock_cnt != 5'h1F) lock_cnt <= lock_cnt + 5'h1;
  end
  assign synth_phase_lock = (lock_cnt == 5'h1F);
endmodule

// ### verif/power_mode_reset_sequencer_bench.sv
module power_mode_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, read, write, waitrequest, irq_pending, osc_ok, lock;
  logic chip_reset_n, cpu_run, rc_pwr, rc_gate, regulator_on, boot_start, synth_enable, synth_connected;
  logic [7:0]          address, cpu_div, usb_div;
  logic [31:0]         writedata, readdata, q;
  logic [15:0]         gate;
  logic [3:0]          lanes;
  pmr_pkg::reset_src_t reset_src;
  pmr_pkg::wake_src_t  wake_src;
  pmr_pkg::clk_src_t   clk_src;
  int                  error_cnt = 0, compares = 0, cyc = 0, n;
  power_mode_reset_sequencer i_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(lanes), .readdata(readdata), .waitrequest(waitrequest),
    .reset_src(reset_src), .wake_src(wake_src), .irq_pending(irq_pending), .main_osc_running(osc_ok),
    .synth_phase_lock(lock), .chip_reset_n(chip_reset_n), .cpu_run(cpu_run), .internal_rc_oscillator_power(rc_pwr),
    .internal_rc_oscillator_gate(rc_gate), .regulator_on(regulator_on), .boot_start(boot_start),
    .synth_reference_sel(), .synth_enable(synth_enable), .synth_connected(synth_connected), .synth_cfg(),
    .processor_clock_src(clk_src), .processor_clock_div(cpu_div), .usb_clock_div(usb_div),
    .periph_clk_gate(gate), .periph_clk_div());
  osc_partner i_osc (.clock(clock), .rst_n(rst_n), .synth_enable(synth_enable), .main_osc_running(osc_ok),
    .synth_phase_lock(lock));
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon access; holds until waitrequest is seen low
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_hi(input bit boot);
    n = 0;
    while ((boot ? chip_reset_n : cpu_run) !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic mode(input logic [31:0] m);
    bus(1, pmr_pkg::ADDR_PWR_MODE, m);
    repeat (4) @(posedge clock);
  endtask
  // Clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // Test sequence
  initial begin
    rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = '0;
    reset_src = '0; wake_src = '0; irq_pending = 1'b0; lanes = 4'hF;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    wait_hi(1);
    chk("hold", 32'h1, 32'(n >= 4096));
    chk("boot", 32'h1, 32'(boot_start));
    chk("src", 32'(pmr_pkg::SRC_RC), 32'(clk_src));
    chk("synth off", 32'h0, 32'(synth_enable));
    bus(0, pmr_pkg::ADDR_PCLK_GATE, 0); chk("gate rst", pmr_pkg::PCLK_GATE_RESET, q);
    bus(1, pmr_pkg::ADDR_PCLK_GATE, 32'h0000_00A5); chk("gate", 32'h0000_00A5, 32'(gate));
    bus(1, pmr_pkg::ADDR_SYNTH_CFG, 32'h0000_0000);
    bus(0, pmr_pkg::ADDR_SYNTH_CFG, 0); chk("cfg low", 32'h0001_0001, q);
    bus(1, pmr_pkg::ADDR_SYNTH_CFG, 32'hFFFF_01FF);
    bus(0, pmr_pkg::ADDR_SYNTH_CFG, 0); chk("cfg high", 32'h8000_0100, q);
    bus(1, pmr_pkg::ADDR_SYNTH_CFG, 32'h0064_0001);
    bus(0, pmr_pkg::ADDR_SYNTH_CFG, 0);
    chk("cfg run", 32'h0064_0001, q);
    bus(0, 8'h3C, 0); chk("unmapped", pmr_pkg::UNMAPPED_READ, q);
    bus(1, pmr_pkg::ADDR_PCLK_DIV, 32'h1234_5678);
    lanes <= 4'h3;
    bus(1, pmr_pkg::ADDR_PCLK_DIV, 32'h0000_0000);
    lanes <= 4'hF;
    bus(0, pmr_pkg::ADDR_PCLK_DIV, 0);
    chk("pdiv", 32'h1234_5678, q);
    $display("test reset and registers done");
    bus(1, pmr_pkg::ADDR_SYNTH_CTRL, 32'h0000_0003);
    chk("early connect", 32'h0, 32'(synth_connected));
    n = 0;
    do begin
      bus(0, pmr_pkg::ADDR_STATUS, 0);
      n++;
    end while (q[5] !== 1'b1 && n < 50);
    bus(1, pmr_pkg::ADDR_SYNTH_CTRL, 32'h0000_0003); chk("connect", 32'h1, 32'(synth_connected));
    bus(1, pmr_pkg::ADDR_CPU_DIV, 32'h0000_0003);
    bus(1, pmr_pkg::ADDR_USB_DIV, 32'h0000_0005);
    mode(32'h0000_0002);
    chk("sleep clocks", 32'h0, 32'({synth_enable, synth_connected, cpu_div, usb_div, rc_gate, cpu_run}));
    chk("sleep rc pwr", 32'h1, 32'(rc_pwr));
    wake_src.clockless_int <= 1'b1;
    @(posedge clock);
    wake_src.clockless_int <= 1'b0;
    wait_hi(0);
    chk("sleep wake", 32'h1, 32'(n >= 4 && n <= 8));
    bus(1, pmr_pkg::ADDR_CPU_DIV, 32'h0000_0003);
    chk("div again", 32'h3, 32'(cpu_div));
    bus(1, pmr_pkg::ADDR_CLK_SEL, 32'h0000_0001);
    repeat (4) @(posedge clock);
    chk("src main", 32'(pmr_pkg::SRC_MAIN), 32'(clk_src));
    mode(32'h0000_0002);
    wake_src.clockless_int <= 1'b1;
    @(posedge clock);
    wake_src.clockless_int <= 1'b0;
    wait_hi(0);
    chk("main wake", 32'h1, 32'(n >= 4096 && n <= 4100));
    bus(1, pmr_pkg::ADDR_CLK_SEL, 32'h0000_0000);
    repeat (4) @(posedge clock);
    mode(32'h0000_0001);
    chk("idle", 32'h1, 32'({cpu_run, rc_gate}));
    irq_pending <= 1'b1;
    wait_hi(0);
    irq_pending <= 1'b0;
    chk("idle wake", 32'h1, 32'(n <= 4));
    bus(1, pmr_pkg::ADDR_SYNTH_CTRL, 32'h0000_0001);
    mode(32'h0000_0003);
    chk("pd", 32'h0, 32'({rc_pwr, synth_enable}));
    wake_src.external_int <= 1'b1;
    @(posedge clock);
    wake_src.external_int <= 1'b0;
    wait_hi(0);
    chk("pd wake", 32'h1, 32'(n >= 1204 && n <= 1212));
    chk("pd src", 32'(pmr_pkg::SRC_RC), 32'(clk_src));
    $display("test power modes done");
    mode(32'h0000_0004);
    wake_src.external_int <= 1'b1;
    repeat (8) @(posedge clock);
    wake_src.external_int <= 1'b0;
    chk("deep", 32'h0, 32'(regulator_on));
    wake_src.rtc_alarm <= 1'b1;
    for (n = 0; n < 20 && regulator_on !== 1'b1; n++) @(posedge clock);
    wake_src.rtc_alarm <= 1'b0;
    wait_hi(1);
    chk("deep hold", 32'h1, 32'(n >= 4096));
    bus(0, pmr_pkg::ADDR_PCLK_GATE, 0); chk("deep regs", pmr_pkg::PCLK_GATE_RESET, q);
    for (int i = 0; i < 4; i++) begin
      reset_src <= pmr_pkg::reset_src_t'(4'h8 >> i);
      repeat (3) @(posedge clock);
      chk("reset src", 32'h0, 32'(chip_reset_n));
      reset_src <= '0;
      wait_hi(1);
      chk("src hold", 32'h1, 32'(n >= 4096));
    end
    $display("test deep and reset sources done");
    wrap_up();
  end
endmodule
